// file: fsr_checker.sv
// Purpose: Assertions on the ports of the fault status block
// Assumes: Mode pins steady until capture
// Notes:   Bind follows the module
`include "fsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module fsr_checker (
    // Clock, reset and APB
    input wire logic               i_sys_clk,
    input wire logic               i_rst_b,
    input wire logic               i_psel,
    input wire logic               i_penable,
    input wire logic               i_pwrite,
    input wire logic [11:0]        i_paddr,
    input wire logic [31:0]        i_pwdata,
    input wire logic [3:0]         i_pstrb,
    input wire logic [31:0]        o_prdata,
    input wire logic               o_pready,
    input wire logic               o_pslverr,
    // Straps and configuration
    input wire logic               i_two_channel,
    input wire fsr_pkg::fsr_pins_t i_mode_pins,
    input wire logic [2:0]         o_comparator_threshold_sel,
    input wire logic [7:0]         o_analog_system_config,
    input wire fsr_pkg::fsr_pins_t o_mode_pin_capture
);
    import fsr_pkg::*;
    // ****************************************************************
    // Decoded bus phases
    // ****************************************************************
    wire logic       acc;  // Access cycle
    wire logic       rds;  // Aligned read setup cycle
    wire logic [5:0] idx;  // Register index
    assign acc = i_psel & i_penable;
    assign idx = i_paddr[7:2];
    assign rds = i_psel & ~i_penable & ~i_pwrite & ~|i_paddr[11:8] & ~|i_paddr[1:0];
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    // ****************************************************************
    // Properties
    // ****************************************************************
    ready_zero_wait_a:
        assert property (o_pready == acc) else $error("pready wrong");
    misalign_err_a:
        assert property (acc && i_paddr[1:0] != 2'b00 |-> o_pslverr) else $error("no slverr");
    idle_quiet_a:
        assert property (!acc |-> !o_pslverr && o_prdata[31:8] == '0) else $error("idle bus");
    neg_upper_zero_a:
        assert property (rds && idx == `FSR_IDX_NEG |=> !o_prdata[7:4]) else $error("neg upper");
    two_chan_zero_a:
        assert property (rds && idx == `FSR_IDX_NEG && i_two_channel |=> o_prdata[3:2] == 2'b00)
            else $error("absent channel");
    rsvd_read_zero_a:
        assert property (rds && idx >= `FSR_IDX_RSV_LO && idx <= `FSR_IDX_RSV_HI |=> !o_prdata)
            else $error("reserved read");
    pin_read_a:
        assert property (rds && idx == `FSR_IDX_PIN
            |=> o_prdata[7:0] == {2'b00, $past(o_mode_pin_capture)})
            else $error("pin read");
    cfg_reset_a:
        assert property ($rose(i_rst_b) |-> o_analog_system_config == `FSR_ACFG_RST)
            else $error("cfg reset");
    thresh_follow_a:
        assert property (o_comparator_threshold_sel == o_analog_system_config[2:0])
            else $error("threshold sel");
    cfg_write_a:
        assert property (acc && i_pwrite && i_pstrb[0] && i_paddr == {4'h0, `FSR_IDX_ACFG, 2'b00}
            |=> o_analog_system_config == $past(i_pwdata[7:0])) else $error("cfg write lost");
    pins_capture_a:
        assert property ($rose(i_rst_b) |-> ##4 (o_mode_pin_capture == i_mode_pins)
            ##1 $stable(o_mode_pin_capture)[*8]) else $error("pin capture");
endmodule
bind fsr_regs fsr_checker u_chk (.i_sys_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_two_channel, .i_mode_pins,
    .o_comparator_threshold_sel, .o_analog_system_config, .o_mode_pin_capture);
`default_nettype wire

// file: fsr_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the fault status block
// Assumes: Byte address of a register is four times its index
// Notes:   Definitions only
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// ****************************************************************
// Register indices
// ****************************************************************
`define FSR_IDX_MAIN    6'h02
`define FSR_IDX_NEG     6'h04
`define FSR_IDX_SER     6'h05
`define FSR_IDX_ERR     6'h06
`define FSR_IDX_PIN     6'h07
`define FSR_IDX_RSV_LO  6'h08
`define FSR_IDX_RSV_HI  6'h0A
`define FSR_IDX_ACFG    6'h0B
`define FSR_IDX_IRQ_ST  6'h10
`define FSR_IDX_IRQ_MSK 6'h11

// ****************************************************************
// Field positions
// ****************************************************************
`define FSR_SER_STARTUP 2
`define FSR_SER_CS      1
`define FSR_SER_FRAME   0
`define FSR_MAIN_SER    5
`define FSR_MAIN_ADCIN  4

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define FSR_ACFG_RST    8'h60
`define FSR_ERR_MAX     8'hFF
`define FSR_WL_24       8'h18
`define FSR_WL_32       8'h20
`define FSR_WL_16       8'h10
`define FSR_FRAME_WORDS 8'h02
`define FSR_CH_ALL      4'hF
`define FSR_CH_TWO      4'h3
`endif

// file: fsr_link_host.sv
// Purpose: Serial host model driving link clock and chip select
// Assumes: Link clock idles low, still between frames
// Notes:   160 ns link clock, unrelated to the system clock
`timescale 1ns/10ps
`default_nettype none
module fsr_link_host (
    // Link pins
    output var logic o_sclk,
    output var logic o_cs_b
);
    // Idle: deselected, clock low
    initial begin
        o_sclk = 1'b0;
        o_cs_b = 1'b1;
    end
    // n pulses; flip ends the frame with the clock high
    task automatic frame(input int n, input bit flip);
        o_cs_b = 1'b0;
        #80;
        repeat (n) begin
            o_sclk = 1'b1;
            #80;
            o_sclk = 1'b0;
            #80;
        end
        o_sclk = flip;
        #80;
        o_cs_b = 1'b1;
        #80;
        o_sclk = 1'b0;
        #400;
    endtask
endmodule
`default_nettype wire

// file: fsr_pkg.sv
// Purpose: Types shared by the fault status block
// Assumes: Nothing
// Notes:   Constants live in fsr_defs.svh
package fsr_pkg;

    // ****************************************************************
    // Captured mode pin codes
    // ****************************************************************
    typedef struct packed {
        logic [1:0] ecc_pin_code;           // Error correction pin
        logic [1:0] word_length_pin_code;   // Word length pin
        logic [1:0] interface_mode_pin_code; // Interface mode pin
    } fsr_pins_t;

    // ****************************************************************
    // Pin capture sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        FSR_CAP_WAIT0 = 2'b00,
        FSR_CAP_WAIT1 = 2'b01,
        FSR_CAP_GRAB  = 2'b10,
        FSR_CAP_DONE  = 2'b11
    } fsr_cap_state_t;

endpackage

// file: fsr_regs.sv
// Purpose: Fault and status register group with APB slave
// Assumes: Link clock and chip select are slow against i_sys_clk
// Notes:   Zero wait state APB; read side effects act at the setup edge
//
// How it works
// - Negative input flags in bits 3:0, 7:4 zero
// - Two-channel part reads channel 3/4 as zero
// - Startup flag bit 2, cleared by reset only
// - Chip select edge while clock high flags
// - Chip select flag clears on serial read
// - Short frame sets frame flag bit 0
// - Frame flag clears on serial read
// - Error counter counts Hamming and CRC errors
// - Error counter saturates at FFh
// - Reading error counter returns then clears it
// - Bits 5:4 report error correction pin
// - Bits 3:2 report word length pin
// - Bits 1:0 report interface mode pin
// - Pin fields captured once after reset and held, bits 7:6 zero
// - Indices 08h to 0Ah read 00h
// - Analog config at 0Bh resets to 60h
// - Summary serial flag cleared by serial read
// - Threshold select drives the input comparators
//
// Design decision made here: the APB register port.
`include "fsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module fsr_regs (
    // Clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_b,
    // APB slave
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    // Serial link pins
    input  wire logic              i_sclk,
    input  wire logic              i_cs_b,
    // Comparators and straps
    input  wire logic [3:0]        i_neg_over_threshold,
    input  wire logic              i_two_channel,
    input  wire fsr_pkg::fsr_pins_t i_mode_pins,
    // Events from the same clock domain
    input  wire logic              i_startup_fault,
    input  wire logic              i_din_error,
    // Outputs to the analog side
    output logic      [2:0]        o_comparator_threshold_sel,
    output logic      [7:0]        o_analog_system_config,
    output fsr_pkg::fsr_pins_t     o_mode_pin_capture,
    // Interrupt
    output logic                   o_irq
);
    import fsr_pkg::*;

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Saturating increment of the error tally
    function automatic logic [7:0] fsr_sat_inc(input logic [7:0] v);
        begin
            if (v == `FSR_ERR_MAX) begin
                fsr_sat_inc = v;           // Hold at maximum
            end else begin
                fsr_sat_inc = v + 8'h01;
            end
        end
    endfunction

    // Bits per word from the word length code
    function automatic logic [7:0] fsr_word_bits(input logic [1:0] code);
        begin
            case (code)
                2'b01:   fsr_word_bits = `FSR_WL_32;
                2'b10:   fsr_word_bits = `FSR_WL_16;
                default: fsr_word_bits = `FSR_WL_24;
            endcase
        end
    endfunction

    // Index decode of implemented registers
    function automatic logic fsr_mapped(input logic [5:0] idx);
        begin
            fsr_mapped = (idx == `FSR_IDX_MAIN) || (idx == `FSR_IDX_NEG)
                || (idx == `FSR_IDX_SER) || (idx == `FSR_IDX_ERR)
                || (idx == `FSR_IDX_PIN) || (idx == `FSR_IDX_ACFG)
                || (idx == `FSR_IDX_IRQ_ST) || (idx == `FSR_IDX_IRQ_MSK)
                || ((idx >= `FSR_IDX_RSV_LO) && (idx <= `FSR_IDX_RSV_HI));
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    localparam int SW = 13;                 // Synchronised input width

    logic [SW-1:0]      sync1_reg;          // First synchroniser stage
    logic [SW-1:0]      sync2_reg;          // Second synchroniser stage
    logic               sclk_d_reg;         // Delayed link clock
    logic               cs_d_reg;           // Delayed chip select
    logic [7:0]         edge_cnt_reg;       // Clock edges in frame
    logic [7:0]         edge_cnt_next;
    fsr_cap_state_t     cap_reg;            // Capture sequencer
    fsr_cap_state_t     cap_next;
    fsr_pins_t          pins_reg;           // Captured pin codes
    logic               two_ch_reg;         // Captured variant strap
    logic [3:0]         neg_reg;            // Negative input flags
    logic [3:0]         neg_next;
    logic               startup_reg;        // Startup fault flag
    logic               cs_flt_reg;         // Chip select fault flag
    logic               cs_flt_next;
    logic               frm_flt_reg;        // Frame fault flag
    logic               frm_flt_next;
    logic               sum_ser_reg;        // Summary serial flag
    logic               sum_ser_next;
    logic               sum_adc_reg;        // Summary input flag
    logic               sum_adc_next;
    logic [7:0]         err_reg;            // Error tally
    logic [7:0]         err_next;
    logic [7:0]         acfg_reg;           // Analog configuration
    logic [4:0]         irq_st_reg;         // Interrupt status
    logic [4:0]         irq_st_next;
    logic [4:0]         irq_msk_reg;        // Interrupt mask
    logic               irq_reg;            // Interrupt output
    logic [31:0]        prdata_reg;         // Read data
    logic               slverr_reg;         // Error answer

    // ****************************************************************
    // Synchronised link and pin signals
    // ****************************************************************
    wire logic          sclk_s   = sync2_reg[12];
    wire logic          cs_s     = sync2_reg[11];
    wire logic [3:0]    neg_s    = sync2_reg[10:7];
    wire fsr_pins_t     pins_s   = sync2_reg[6:1];
    wire logic          two_s    = sync2_reg[0];

    // Chip select moved while the link clock was high
    wire logic          cs_edge  = cs_s ^ cs_d_reg;
    wire logic          cs_evt   = cs_edge & sclk_s & sclk_d_reg;
    wire logic          sclk_up  = sclk_s & ~sclk_d_reg;
    wire logic          frm_end  = cs_s & ~cs_d_reg;
    wire logic          frm_beg  = ~cs_s & cs_d_reg;
    wire logic [7:0]    need     = fsr_word_bits(pins_reg.word_length_pin_code)
                                   * `FSR_FRAME_WORDS;
    wire logic          frm_evt  = frm_end & (edge_cnt_reg < need);

    // Channels present in this variant
    wire logic [3:0]    ch_mask  = two_ch_reg ? `FSR_CH_TWO : `FSR_CH_ALL;
    wire logic [3:0]    neg_set  = neg_s & ch_mask;
    wire logic          neg_evt  = |(neg_set & ~neg_reg);

    // ****************************************************************
    // APB decode
    // ****************************************************************
    wire logic [5:0]    idx      = i_paddr[7:2];
    wire logic          mapped   = fsr_mapped(idx) && (i_paddr[11:8] == 4'h0)
                                   && (i_paddr[1:0] == 2'b00);
    wire logic          setup    = i_psel & ~i_penable;
    wire logic          rd_setup = setup & ~i_pwrite & mapped;
    wire logic          wr_acc   = i_psel & i_penable & i_pwrite & mapped;
    wire logic          rd_neg   = rd_setup & (idx == `FSR_IDX_NEG);
    wire logic          rd_ser   = rd_setup & (idx == `FSR_IDX_SER);
    wire logic          rd_err   = rd_setup & (idx == `FSR_IDX_ERR);
    wire logic          rd_irq   = rd_setup & (idx == `FSR_IDX_IRQ_ST);
    wire logic          wr_acfg  = wr_acc & (idx == `FSR_IDX_ACFG) & i_pstrb[0];
    wire logic          wr_msk   = wr_acc & (idx == `FSR_IDX_IRQ_MSK) & i_pstrb[0];

    // Register images as read
    wire logic [7:0]    ser_img  = {5'h00, startup_reg, cs_flt_reg, frm_flt_reg};
    wire logic [7:0]    main_img = {2'b00, sum_ser_reg, sum_adc_reg, 4'h0};
    wire logic [7:0]    pin_img  = {2'b00, pins_reg};
    wire logic [7:0]    rd_byte  =
        (idx == `FSR_IDX_MAIN)    ? main_img :
        (idx == `FSR_IDX_NEG)     ? {4'h0, neg_reg} :
        (idx == `FSR_IDX_SER)     ? ser_img :
        (idx == `FSR_IDX_ERR)     ? err_reg :
        (idx == `FSR_IDX_PIN)     ? pin_img :
        (idx == `FSR_IDX_ACFG)    ? acfg_reg :
        (idx == `FSR_IDX_IRQ_ST)  ? {3'b000, irq_st_reg} :
        (idx == `FSR_IDX_IRQ_MSK) ? {3'b000, irq_msk_reg} :
        8'h00;
    wire logic [31:0]   rd_data  = mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;

    // ****************************************************************
    // Next values
    // ****************************************************************

    // Frame edge counter restarts at frame start, saturates
    assign edge_cnt_next = frm_beg ? 8'h00 :
                           (sclk_up & ~cs_s) ? fsr_sat_inc(edge_cnt_reg) :
                           edge_cnt_reg;

    // Sticky flags; a new event wins over the read clear
    assign neg_next     = (rd_neg ? 4'h0 : neg_reg) | neg_set;
    assign cs_flt_next  = (cs_flt_reg & ~rd_ser) | cs_evt;
    assign frm_flt_next = (frm_flt_reg & ~rd_ser) | frm_evt;
    assign sum_ser_next = (sum_ser_reg & ~rd_ser)
                          | cs_evt | frm_evt | i_startup_fault;
    assign sum_adc_next = (sum_adc_reg & ~rd_neg) | (|neg_set);

    // Error tally: clear on read, a same-cycle error counts as one
    assign err_next = rd_err ? {7'h00, i_din_error} :
                      i_din_error ? fsr_sat_inc(err_reg) :
                      err_reg;

    // Interrupt status events
    wire logic [4:0] irq_ev = {i_startup_fault & ~startup_reg,
                               i_din_error, frm_evt, cs_evt, neg_evt};
    assign irq_st_next = (rd_irq ? 5'h00 : irq_st_reg) | irq_ev;

    // Capture sequencer waits for the synchroniser to fill
    always_comb begin
        cap_next = cap_reg;
        case (cap_reg)
            FSR_CAP_WAIT0: cap_next = FSR_CAP_WAIT1;
            FSR_CAP_WAIT1: cap_next = FSR_CAP_GRAB;
            FSR_CAP_GRAB:  cap_next = FSR_CAP_DONE;
            FSR_CAP_DONE:  cap_next = FSR_CAP_DONE;
            default:       cap_next = FSR_CAP_WAIT0;
        endcase
    end

    // ****************************************************************
    // Synchronisers and edge history
    // ****************************************************************

    // Two stages for every pin-side input
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= 13'h0800;
            sync2_reg <= 13'h0800;
        end else begin
            sync1_reg <= {i_sclk, i_cs_b, i_neg_over_threshold,
                          i_mode_pins, i_two_channel};
            sync2_reg <= sync1_reg;
        end
    end

    // Edge history, idle chip select is high
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_d_reg   <= 1'b0;
            cs_d_reg     <= 1'b1;
            edge_cnt_reg <= 8'h00;
        end else begin
            sclk_d_reg   <= sclk_s;
            cs_d_reg     <= cs_s;
            edge_cnt_reg <= edge_cnt_next;
        end
    end

    // ****************************************************************
    // Mode pin capture
    // ****************************************************************

    // Pins taken once, then held until the next reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cap_reg    <= FSR_CAP_WAIT0;
            pins_reg   <= 6'h00;
            two_ch_reg <= 1'b0;
        end else begin
            cap_reg <= cap_next;
            if (cap_reg == FSR_CAP_GRAB) begin
                pins_reg   <= pins_s;
                two_ch_reg <= two_s;
            end
        end
    end

    // ****************************************************************
    // Fault flags and counter
    // ****************************************************************

    // Serial and input fault flags
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            neg_reg     <= 4'h0;
            startup_reg <= 1'b0;
            cs_flt_reg  <= 1'b0;
            frm_flt_reg <= 1'b0;
            sum_ser_reg <= 1'b0;
            sum_adc_reg <= 1'b0;
        end else begin
            neg_reg     <= neg_next;
            startup_reg <= startup_reg | i_startup_fault;
            cs_flt_reg  <= cs_flt_next;
            frm_flt_reg <= frm_flt_next;
            sum_ser_reg <= sum_ser_next;
            sum_adc_reg <= sum_adc_next;
        end
    end

    // Error tally
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            err_reg <= 8'h00;
        end else begin
            err_reg <= err_next;
        end
    end

    // ****************************************************************
    // Configuration and interrupt registers
    // ****************************************************************

    // Analog configuration and interrupt mask
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            acfg_reg    <= `FSR_ACFG_RST;
            irq_msk_reg <= 5'h00;
        end else begin
            if (wr_acfg) begin
                acfg_reg <= i_pwdata[7:0];
            end
            if (wr_msk) begin
                irq_msk_reg <= i_pwdata[4:0];
            end
        end
    end

    // Interrupt status and level output
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            irq_st_reg <= 5'h00;
            irq_reg    <= 1'b0;
        end else begin
            irq_st_reg <= irq_st_next;
            irq_reg    <= |(irq_st_next & irq_msk_reg);
        end
    end

    // ****************************************************************
    // APB answer
    // ****************************************************************

    // Read data and error latched in the setup cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata_reg <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end else if (setup) begin
            prdata_reg <= i_pwrite ? 32'h0000_0000 : rd_data;
            slverr_reg <= ~mapped;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign o_prdata                   = prdata_reg;
    assign o_pready                   = i_psel & i_penable;
    assign o_pslverr                  = i_psel & i_penable & slverr_reg;
    assign o_comparator_threshold_sel = acfg_reg[2:0];
    assign o_analog_system_config     = acfg_reg;
    assign o_mode_pin_capture         = pins_reg;
    assign o_irq                      = irq_reg;

endmodule

`default_nettype wire

// file: tb.sv
// Purpose: Self-checking bench of the fault status block
// Assumes: Link host model on the serial pins
// Notes:   Mode pins 01/00/10 first, 10/01/00 after the second reset
`include "fsr_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
    import fsr_pkg::*;
    logic        i_sys_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_two_channel;
    logic        i_startup_fault, i_din_error, o_pready, o_pslverr, o_irq;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [3:0]  i_pstrb, i_neg_over_threshold;
    logic [2:0]  o_comparator_threshold_sel;
    logic [7:0]  o_analog_system_config;
    fsr_pins_t   i_mode_pins, o_mode_pin_capture;
    wire         i_sclk, i_cs_b;
    int          input_error_counter, n_tests;
    fsr_regs DUT (.i_sys_clk, .i_rst_b, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
        .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_sclk, .i_cs_b, .i_neg_over_threshold,
        .i_two_channel, .i_mode_pins, .i_startup_fault, .i_din_error, .o_comparator_threshold_sel,
        .o_analog_system_config, .o_mode_pin_capture, .o_irq);
    fsr_link_host host (.o_sclk(i_sclk), .o_cs_b(i_cs_b));
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            input_error_counter++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One APB transfer
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge i_sys_clk);
        i_psel   <= 1'b1;
        i_pwrite <= wr;
        i_paddr  <= ad;
        i_pwdata <= wd;
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_sys_clk);
        end while (o_pready !== 1'b1);
        rd = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [5:0] ix, input logic [31:0] exp, input string nm);
        logic [31:0] d;
        logic        e;
        apb(1'b0, {4'h0, ix, 2'b00}, 32'h0000_0000, d, e);
        chk(nm, d, exp);
    endtask
    task automatic wr(input logic [5:0] ix, input logic [31:0] wd);
        logic [31:0] d;
        logic        e;
        apb(1'b1, {4'h0, ix, 2'b00}, wd, d, e);
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge i_sys_clk);
            i_din_error <= 1'b1;
            @(posedge i_sys_clk);
            i_din_error <= 1'b0;
        end
    endtask
    task automatic reset(input logic two, input fsr_pins_t pins);
        i_rst_b       <= 1'b0;
        i_two_channel <= two;
        i_mode_pins   <= pins;
        repeat (12) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
    endtask
    // Reset values, map holes and bus errors
    task automatic s_map();
        logic [31:0] d;
        logic        e;
        rdchk(`FSR_IDX_ACFG, 32'h0000_0060, "cfg reset");
        rdchk(`FSR_IDX_PIN, 32'h0000_0012, "pin codes");
        for (int i = 8; i <= 10; i++) rdchk(i[5:0], 32'h0000_0000, "reserved");
        apb(1'b0, 12'h0FC, 32'h0000_0000, d, e);
        chk("unmapped", e, 1'b1);
        apb(1'b0, 12'h019, 32'h0000_0000, d, e);
        chk("misaligned", e, 1'b1);
    endtask
    // Comparator flags
    task automatic s_neg(input logic [31:0] exp);
        i_neg_over_threshold <= 4'hF;
        repeat (6) @(posedge i_sys_clk);
        i_neg_over_threshold <= 4'h0;
        repeat (6) @(posedge i_sys_clk);
        rdchk(`FSR_IDX_NEG, exp, "neg flags");
        rdchk(`FSR_IDX_NEG, 32'h0000_0000, "neg cleared");
    endtask
    // Serial link faults
    task automatic s_serial();
        i_startup_fault <= 1'b1;
        @(posedge i_sys_clk);
        i_startup_fault <= 1'b0;
        host.frame(10, 1'b0);
        rdchk(`FSR_IDX_MAIN, 32'h0000_0020, "serial summary");
        rdchk(`FSR_IDX_SER, 32'h0000_0005, "short frame");
        rdchk(`FSR_IDX_SER, 32'h0000_0004, "frame cleared");
        host.frame(48, 1'b0);
        rdchk(`FSR_IDX_SER, 32'h0000_0004, "full frame");
        host.frame(48, 1'b1);
        rdchk(`FSR_IDX_SER, 32'h0000_0006, "cs fault");
        rdchk(`FSR_IDX_SER, 32'h0000_0004, "cs cleared");
    endtask
    // Error tally
    task automatic s_err();
        pulse(3);
        rdchk(`FSR_IDX_ERR, 32'h0000_0003, "tally");
        rdchk(`FSR_IDX_ERR, 32'h0000_0000, "tally cleared");
        pulse(260);
        rdchk(`FSR_IDX_ERR, 32'h0000_00FF, "tally saturated");
    endtask
    // Interrupt and threshold select
    task automatic s_irq();
        wr(`FSR_IDX_IRQ_MSK, 32'h0000_0008);
        rdchk(`FSR_IDX_IRQ_ST, 32'h0000_001F, "status old");
        pulse(1);
        repeat (4) @(posedge i_sys_clk);
        chk("irq raised", o_irq, 1'b1);
        rdchk(`FSR_IDX_IRQ_ST, 32'h0000_0008, "status");
        repeat (4) @(posedge i_sys_clk);
        chk("irq cleared", o_irq, 1'b0);
        wr(`FSR_IDX_IRQ_MSK, 32'h0000_0000);
        pulse(1);
        repeat (4) @(posedge i_sys_clk);
        chk("irq masked", o_irq, 1'b0);
        wr(`FSR_IDX_ACFG, 32'h0000_0065);
        rdchk(`FSR_IDX_ACFG, 32'h0000_0065, "cfg readback");
        chk("threshold sel", o_comparator_threshold_sel, 3'h5);
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, input_error_counter);
        if (input_error_counter == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        #400_000;
        input_error_counter++;
        end_sim();
    end
    initial begin
        i_rst_b = 1'b0;
        {i_psel, i_penable, i_pwrite, i_two_channel, i_startup_fault, i_din_error} = '0;
        i_paddr = 12'h000;
        i_pwdata = 32'h0000_0000;
        i_pstrb = 4'hF;
        i_neg_over_threshold = 4'h0;
        reset(1'b0, 6'b01_00_10);
        s_map();
        s_neg(32'h0000_000F);
        s_serial();
        s_err();
        s_irq();
        reset(1'b1, 6'b10_01_00);
        rdchk(`FSR_IDX_ACFG, 32'h0000_0060, "cfg reset 2");
        repeat (20) @(posedge i_sys_clk);
        i_mode_pins <= 6'b00_10_01;
        rdchk(`FSR_IDX_PIN, 32'h0000_0024, "pins held");
        host.frame(48, 1'b0);
        rdchk(`FSR_IDX_SER, 32'h0000_0001, "frame 32");
        s_neg(32'h0000_0003);
        end_sim();
    end
endmodule
`default_nettype wire
